//--- logic/hcd_pkg.sv
/*
 holds the shared constants and carrier types of the host command decoder.
 assumes a 32-bit apb master and byte-wide command parameters.
*/
package hcd_pkg;
    // command opcodes; configure opcode value is local
    localparam logic [7:0] OP_CONF = 8'h01;
    localparam logic [7:0] OP_HANDSHAKE = 8'h04;
    localparam logic [7:0] OP_INIT = 8'h06;
    localparam logic [7:0] OP_ERR_CLEAR = 8'h08;
    localparam logic [7:0] OP_LINE_FRAMING_CMD = 8'h09;
    localparam logic [7:0] OP_MONITOR = 8'h0a;
    localparam logic [7:0] OP_TONE_DEF = 8'h0e;
    localparam logic [7:0] OP_CX_READ = 8'h11;
    localparam logic [7:0] OP_IRQ_MASK = 8'h13;
    localparam logic [7:0] OP_RELEASE = 8'h14;
    localparam logic [7:0] OP_FW_CALL = 8'h18;
    // register byte offsets
    localparam logic [7:0] OFF_PARAM = 8'h00;
    localparam logic [7:0] OFF_OPCODE = 8'h04;
    localparam logic [7:0] OFF_CFG = 8'h08;
    localparam logic [7:0] OFF_LINE = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_ERR = 8'h14;
    localparam logic [7:0] OFF_ACK = 8'h18;
    localparam logic [7:0] OFF_CX = 8'h1c;
    localparam logic [7:0] OFF_REL = 8'h20;
    localparam logic [7:0] OFF_RAM = 8'h24;
    // operating modes
    localparam logic [3:0] MODE_TONE = 4'h0;
    localparam logic [3:0] MODE_TONECID = 4'h1;
    localparam logic [3:0] MODE_DECODER = 4'h2;
    localparam logic [3:0] MODE_TRANSP = 4'h4;
    localparam logic [3:0] MODE_CODER = 4'h8;
    localparam logic [3:0] MODE_ROOM = 4'h9;
    localparam logic [3:0] MODE_HANDS = 4'hc;
    localparam logic [3:0] MODE_MODEM = 4'hf;
    localparam logic [1:0] RATE_RSVD = 2'h3;
    localparam logic [1:0] PAR_RSVD = 2'h3;
    // line formats
    localparam logic [2:0] FMT_SYNC = 3'h0;
    localparam logic [2:0] FMT_ONES = 3'h1;
    localparam logic [2:0] FMT_ZEROS = 3'h3;
    localparam logic [2:0] FMT_UART = 3'h4;
    // reset values; release codes are arbitrary
    localparam logic [7:0] MASK0_RST = 8'h3f;
    localparam logic [7:0] MASK1_RST = 8'hff;
    localparam logic [7:0] HW_REL = 8'h01;
    localparam logic [7:0] SW_REL = 8'h01;
    localparam int RAM_AW = 4;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;
    typedef struct packed {
        logic adpcm_sel;
        logic decoder_postfilter_en;
        logic [1:0] adpcm_rate_sel;
        logic vocoder_line_echo_en;
        logic coder_source_sel;
        logic silence_suppress_en;
        logic decoder_error_fix_en;
    } voc_cfg_s;
    typedef struct packed {
        logic telephony_init_inhibit;
        logic handsfree_sel;
        logic line_echo_disable;
        logic audio_echo_disable;
        logic half_duplex_sel;
        logic rx_clip_disable;
        logic gain_freeze;
        logic tx_clip_disable;
    } hs_cfg_s;
    typedef struct packed {
        logic [3:0] op_mode_sel;
        logic room_line_echo_en;
        voc_cfg_s voc;
        hs_cfg_s hs;
    } cfg_s;
    typedef struct packed {
        logic [2:0] tx_format;
        logic [2:0] rx_format;
        logic [1:0] char_width_sel;
        logic [1:0] parity_sel;
        logic stop_count_sel;
    } line_cfg_s;
    typedef struct packed {
        logic [11:0] freq;
        logic [7:0] amp;
    } tone_s;
    typedef struct packed {
        logic [11:0] addr;
        logic monitor_byte_sel;
    } mon_slot_s;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] arg;
    } call_s;
    localparam cfg_s CFG_RST = '0;
    localparam line_cfg_s LINE_RST = '0;
endpackage

//--- logic/cx_param_ram.sv
/*
 holds the complex parameter memory read by the decoder.
 assumes one clock and a clock enable shared with the decoder.
*/
module cx_param_ram (
    input wire logic pclk,
    input wire logic ce,
    input wire logic we,
    input wire logic [hcd_pkg::RAM_AW-1:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [hcd_pkg::RAM_AW-1:0] raddr,
    output logic [15:0] rdata
);
    import hcd_pkg::*;
    logic [15:0] mem [0:(1<<RAM_AW)-1];

    // synchronous read, one cycle of latency; no reset so it maps to ram
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule

//--- logic/host_command_decoder.sv
/*
 holds the host command decoder: apb registers, opcode execution, config state.
 assumes the host writes parameters, then the opcode, and waits for cmd_ack.
*/
module host_command_decoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire hcd_pkg::apb_req_s apb,
    output hcd_pkg::apb_rsp_s apb_rsp,
    input wire logic [7:0] status0,
    input wire logic [7:0] status1,
    input wire logic [7:0] err_set,
    input wire logic hs_done,
    output hcd_pkg::cfg_s cfg,
    output hcd_pkg::line_cfg_s line_cfg,
    output hcd_pkg::tone_s [3:0] tones,
    output hcd_pkg::mon_slot_s [3:0] monitor_slots,
    output hcd_pkg::call_s call,
    output logic fw_call,
    output logic hs_start,
    output logic cmd_ack,
    output logic status_change_irq,
    output logic soft_restart
);
    import hcd_pkg::*;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_exec = 2'b01,
        st_cx_real = 2'b10,
        st_cx_imag = 2'b11
    } state_e;

    state_e state;
    logic [31:0] param;
    logic [7:0] opcode;
    logic [7:0] status0_irq_mask;
    logic [7:0] status1_irq_mask;
    logic [7:0] system_error_byte;
    logic [7:0] command_ack_counter;
    logic [7:0] status0_prev;
    logic [7:0] status1_prev;
    logic hs_active;
    logic [15:0] cx_reply;
    logic [15:0] rel_reply;
    logic [15:0] ram_rdata;

    function automatic logic mode_valid(input logic [3:0] m);
        mode_valid = m == MODE_TONE || m == MODE_TONECID || m == MODE_DECODER || m == MODE_TRANSP
            || m == MODE_CODER || m == MODE_ROOM || m == MODE_HANDS || m == MODE_MODEM;
    endfunction

    // parameter bytes as numbered by the host
    wire [7:0] b1 = param[7:0];
    wire [7:0] b2 = param[15:8];
    wire [7:0] b3 = param[23:16];
    wire [7:0] b4 = param[31:24];

    // apb decode; writes are taken at the access edge only
    wire setup = apb.psel & ~apb.penable;
    wire access = apb.psel & apb.penable & apb_rsp.pready;
    wire wr = access & apb.pwrite;
    wire busy = state != st_idle;
    wire hit_param = apb.paddr == OFF_PARAM;
    wire hit_op = apb.paddr == OFF_OPCODE;
    wire hit_ram = apb.paddr == OFF_RAM;
    wire mapped = apb.paddr <= OFF_RAM && apb.paddr[1:0] == 2'h0;
    wire param_wr = wr & hit_param & ~busy;
    wire op_wr = wr & hit_op & ~busy;
    wire ram_we = wr & hit_ram;

    // read mux; unmapped and write-only offsets read zero
    wire [31:0] rdata_mux =
        apb.paddr == OFF_PARAM ? param :
        apb.paddr == OFF_OPCODE ? {23'h0, busy, opcode} :
        apb.paddr == OFF_CFG ? {11'h0, cfg} :
        apb.paddr == OFF_LINE ? {21'h0, line_cfg} :
        apb.paddr == OFF_MASK ? {16'h0, status1_irq_mask, status0_irq_mask} :
        apb.paddr == OFF_ERR ? {24'h0, system_error_byte} :
        apb.paddr == OFF_ACK ? {23'h0, hs_active, command_ack_counter} :
        apb.paddr == OFF_CX ? {16'h0, cx_reply} :
        apb.paddr == OFF_REL ? {16'h0, rel_reply} : 32'h0;

    // one wait-free access phase; data sampled in setup so read is one cycle old
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_rsp <= '0;
        end else if (ce) begin
            if (setup) begin
                apb_rsp.pready <= 1'b1;
                apb_rsp.prdata <= rdata_mux;
                apb_rsp.pslverr <= ~mapped;
            end else if (access) begin
                apb_rsp.pready <= 1'b0;
                apb_rsp.pslverr <= 1'b0;
            end
        end
    end

    // parameter and opcode latches; refused while a command is running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            param <= 32'h0;
            opcode <= 8'h00;
        end else if (ce) begin
            if (param_wr) begin
                param <= apb.pwdata;
            end
            if (op_wr) begin
                opcode <= apb.pwdata[7:0];
            end
        end
    end

    // execution strobes, one per opcode
    wire exec_now = state == st_exec;
    wire ex_conf = exec_now & (opcode == OP_CONF);
    wire ex_handshake = exec_now & (opcode == OP_HANDSHAKE);
    wire ex_init = exec_now & (opcode == OP_INIT);
    wire ex_err_clear = exec_now & (opcode == OP_ERR_CLEAR);
    wire ex_line_framing_cmd = exec_now & (opcode == OP_LINE_FRAMING_CMD);
    wire ex_monitor = exec_now & (opcode == OP_MONITOR);
    wire ex_tone = exec_now & (opcode == OP_TONE_DEF);
    wire ex_cx_read = exec_now & (opcode == OP_CX_READ);
    wire ex_irq_mask = exec_now & (opcode == OP_IRQ_MASK);
    wire ex_release = exec_now & (opcode == OP_RELEASE);
    wire ex_fw_call = exec_now & (opcode == OP_FW_CALL);
    // unknown opcodes still ack so the host never hangs
    wire go_ack = (exec_now & ~ex_cx_read & ~ex_init) | (state == st_cx_imag);

    // sequencer: complex read needs two ram reads, the rest finish in one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= st_idle;
        end else if (ce) begin
            unique case (state)
                st_idle: state <= op_wr ? st_exec : st_idle;
                st_exec: state <= ex_cx_read ? st_cx_real : st_idle;
                st_cx_real: state <= st_cx_imag;
                st_cx_imag: state <= st_idle;
            endcase
        end
    end

    // ack counter and pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_ack_counter <= 8'h00;
            cmd_ack <= 1'b0;
        end else if (ce) begin
            cmd_ack <= go_ack;
            command_ack_counter <= command_ack_counter + {7'h0, go_ack};
        end
    end

    // configure command decode
    wire [3:0] new_mode = b1[3:0];
    wire mode_ok = mode_valid(new_mode);
    wire is_voc = new_mode == MODE_DECODER || new_mode == MODE_CODER;
    wire voc_cfg_s next_voc = '{
        adpcm_sel: b3[0],
        decoder_postfilter_en: b3[1] & ~b3[0],
        adpcm_rate_sel: b3[3:2] == RATE_RSVD ? cfg.voc.adpcm_rate_sel : b3[3:2],
        vocoder_line_echo_en: b3[4],
        coder_source_sel: b3[5],
        silence_suppress_en: b3[6],
        decoder_error_fix_en: b3[7]
    };
    wire hs_cfg_s next_hs = '{
        telephony_init_inhibit: b3[6],
        handsfree_sel: b3[7],
        line_echo_disable: b4[0],
        audio_echo_disable: b4[1],
        half_duplex_sel: b4[2],
        rx_clip_disable: b4[3],
        gain_freeze: b4[4],
        tx_clip_disable: b4[5]
    };

    // operating configuration; other modes keep fields of the ones not chosen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CFG_RST;
        end else if (ce) begin
            if (ex_init) begin
                cfg <= CFG_RST;
            end else if (ex_conf && mode_ok) begin
                cfg.op_mode_sel <= new_mode;
                if (is_voc) begin
                    cfg.voc <= next_voc;
                end
                if (new_mode == MODE_ROOM) begin
                    cfg.room_line_echo_en <= b3[4];
                end
                if (new_mode == MODE_HANDS) begin
                    cfg.hs <= next_hs;
                end
            end
        end
    end

    // line format; fill patterns are a transmit matter, so rx sees synchronous
    wire fmt_ok = b1[2:0] <= FMT_UART;
    wire fill_fmt = b1[2:0] == FMT_ONES || b1[2:0] == FMT_ZEROS;
    wire is_uart = b1[2:0] == FMT_UART;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_cfg <= LINE_RST;
        end else if (ce) begin
            if (ex_init) begin
                line_cfg <= LINE_RST;
            end else if (ex_line_framing_cmd && fmt_ok) begin
                line_cfg.tx_format <= b1[2:0];
                line_cfg.rx_format <= fill_fmt ? FMT_SYNC : b1[2:0];
                if (is_uart && !b2[1]) begin
                    line_cfg.char_width_sel <= b2[1:0];
                end
                if (is_uart && b2[3:2] != PAR_RSVD) begin
                    line_cfg.parity_sel <= b2[3:2];
                end
                if (is_uart) begin
                    line_cfg.stop_count_sel <= b2[5];
                end
            end
        end
    end

    // status interrupt masks and change detector
    wire irq_hit = |(((status0 ^ status0_prev) & status0_irq_mask) | ((status1 ^ status1_prev) & status1_irq_mask));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status0_irq_mask <= MASK0_RST;
            status1_irq_mask <= MASK1_RST;
            status0_prev <= 8'h00;
            status1_prev <= 8'h00;
            status_change_irq <= 1'b0;
        end else if (ce) begin
            status0_prev <= status0;
            status1_prev <= status1;
            status_change_irq <= irq_hit;
            if (ex_init) begin
                status0_irq_mask <= MASK0_RST;
                status1_irq_mask <= MASK1_RST;
            end else if (ex_irq_mask) begin
                status0_irq_mask <= b1;
                status1_irq_mask <= b2;
            end
        end
    end

    // error byte: a new error in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_error_byte <= 8'h00;
        end else if (ce) begin
            system_error_byte <= (system_error_byte & ~(ex_err_clear ? b1 : 8'h00)) | err_set;
        end
    end

    // tone generators and monitor slots, indexed by byte 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tones <= '0;
            monitor_slots <= '0;
        end else if (ce) begin
            if (ex_init) begin
                tones <= '0;
                monitor_slots <= '0;
            end else if (ex_tone) begin
                tones[b1[1:0]] <= '{freq: {b3[3:0], b2}, amp: b4};
            end else if (ex_monitor) begin
                monitor_slots[b1[1:0]] <= '{addr: {b3[3:0], b2}, monitor_byte_sel: b3[7]};
            end
        end
    end

    // firmware call, handshake, identify and restart strobes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call <= '0;
            fw_call <= 1'b0;
            hs_start <= 1'b0;
            hs_active <= 1'b0;
            rel_reply <= 16'h0000;
            soft_restart <= 1'b0;
        end else if (ce) begin
            fw_call <= ex_fw_call;
            hs_start <= ex_handshake;
            soft_restart <= ex_init;
            hs_active <= ex_handshake | (hs_active & ~hs_done);
            if (ex_fw_call) begin
                call <= '{addr: {b2, b1}, arg: {b4, b3}};
            end
            if (ex_release) begin
                rel_reply <= {HW_REL, SW_REL};
            end
        end
    end

    // complex read: real word at the address, imaginary at the next one
    wire [RAM_AW-1:0] cx_addr = b1[RAM_AW-1:0];
    wire [RAM_AW-1:0] ram_raddr = state == st_cx_real ? cx_addr + 1'b1 : cx_addr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cx_reply <= 16'h0000;
        end else if (ce) begin
            if (state == st_cx_real) begin
                cx_reply[15:8] <= ram_rdata[15:8];
            end
            if (state == st_cx_imag) begin
                cx_reply[7:0] <= ram_rdata[15:8];
            end
        end
    end

    cx_param_ram u_ram (
        .pclk(pclk),
        .ce(ce),
        .we(ram_we),
        .waddr(apb.pwdata[16 +: RAM_AW]),
        .wdata(apb.pwdata[15:0]),
        .raddr(ram_raddr),
        .rdata(ram_rdata)
    );

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ack_count_step: assert property (cmd_ack |-> command_ack_counter == $past(command_ack_counter) + 8'h01)
        else $error("ack pulse without counter step");
    a_init_no_ack: assert property (ce && ex_init |=> !cmd_ack && $stable(command_ack_counter))
        else $error("init command acknowledged");
    a_init_masks: assert property (ce && ex_init |=> status0_irq_mask == MASK0_RST && status1_irq_mask == MASK1_RST)
        else $error("masks not restored");
    a_pf_adpcm: assert property (cfg.voc.adpcm_sel |-> !cfg.voc.decoder_postfilter_en)
        else $error("post filter on with adpcm");
    a_rate_reserved: assert property (ce && ex_conf && is_voc && b3[3:2] == RATE_RSVD |=> $stable(cfg.voc.adpcm_rate_sel))
        else $error("reserved rate accepted");
    a_irq_masked: assert property (ce |=> status_change_irq == $past(irq_hit))
        else $error("status interrupt wrong");
    a_err_clear: assert property (ce && ex_err_clear && err_set == 8'h00 |=> (system_error_byte & $past(b1)) == 8'h00)
        else $error("error bits not cleared");
    a_cx_latency: assert property (ce && ex_cx_read ##1 ce ##1 ce |=> cmd_ack && !busy)
        else $error("complex read late");
    a_fmt_reserved: assert property (ce && ex_line_framing_cmd && !fmt_ok |=> $stable(line_cfg))
        else $error("reserved format accepted");
    a_rx_no_fill: assert property (line_cfg.rx_format != FMT_ONES && line_cfg.rx_format != FMT_ZEROS)
        else $error("fill pattern on receive");

    c_complex_read: cover property (ce && ex_cx_read);
    c_soft_init: cover property (ce && ex_init);
    c_status_irq: cover property (status_change_irq);
    c_uart_format: cover property (ce && ex_line_framing_cmd && is_uart);
endmodule

//--- sim/host_mcu.sv
/*
 host controller model: an apb master that issues single word transfers.
 assumes a free running pclk and a slave that answers with pready.
*/
module host_mcu (
    input wire logic pclk,
    output hcd_pkg::apb_req_s req,
    input wire hcd_pkg::apb_rsp_s rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    import hcd_pkg::*;
    initial req = '0;
    // request held until pready is seen at a rising edge; only the bench timeout ends a dead wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge pclk);
        req <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
    endtask
endmodule

//--- sim/host_command_decoder_tb.sv
/*
 self-checking bench for the host command decoder.
 assumes the host model drives apb and commands finish within five cycles.
*/
module host_command_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hcd_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, hs_done = 1'b0, e;
    logic [7:0] status0 = '0, status1 = '0, err_set = '0;
    logic [31:0] q;
    apb_req_s req;
    apb_rsp_s rsp;
    cfg_s cfg;
    line_cfg_s line_cfg;
    tone_s [3:0] tones;
    mon_slot_s [3:0] slots;
    call_s call;
    logic fw_call, hs_start, cmd_ack, irq, soft_restart;
    int n_fail = 0, compares = 0, cyc = 0, n_cmd = 0, n_ack = 0, n_hs = 0, n_fw = 0, n_irq = 0, n_rst = 0;
    host_command_decoder dut (.pclk(pclk), .presetn(presetn), .ce(ce), .apb(req), .apb_rsp(rsp),
        .status0(status0), .status1(status1), .err_set(err_set), .hs_done(hs_done), .cfg(cfg),
        .line_cfg(line_cfg), .tones(tones), .monitor_slots(slots), .call(call), .fw_call(fw_call),
        .hs_start(hs_start), .cmd_ack(cmd_ack), .status_change_irq(irq), .soft_restart(soft_restart));
    host_mcu host (.pclk(pclk), .req(req), .rsp(rsp));
    always #12.5 pclk = ~pclk;
    // pulse counters see pre-edge values, so each one-cycle pulse counts once
    always @(posedge pclk) begin
        cyc++;
        n_ack += (cmd_ack === 1'b1);
        n_hs += (hs_start === 1'b1);
        n_fw += (fw_call === 1'b1);
        n_irq += (irq === 1'b1);
        n_rst += (soft_restart === 1'b1);
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end
    task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
        compares++;
        if (g !== x) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic rdc(string nm, logic [7:0] a, logic [31:0] x);
        host.xfer(1'b0, a, '0, q, e);
        chk(nm, x, q);
    endtask
    // the fixed wait covers the four-cycle worst case answer of a command
    task automatic cmd(logic [31:0] p, logic [7:0] op);
        host.xfer(1'b1, OFF_PARAM, p, q, e);
        host.xfer(1'b1, OFF_OPCODE, {24'h0, op}, q, e);
        n_cmd += (op != OP_INIT);
        repeat (5) @(posedge pclk);
    endtask
    task automatic t_reset();
        rdc("mask", OFF_MASK, {16'h0, MASK1_RST, MASK0_RST});
        chk("cfg", '0, cfg);
        host.xfer(1'b0, 8'h28, '0, q, e);
        chk("slverr", 1, e);
        $display("test reset done");
    endtask
    task automatic t_cfg();
        cmd(32'h00f7_0002, OP_CONF);
        chk("voc", 8'h9f, cfg.voc);
        cmd(32'h000c_0008, OP_CONF);
        chk("rate", 8'h10, cfg.voc);
        cmd(32'h0002_0008, OP_CONF);
        chk("pfilt", 8'h40, cfg.voc);
        cmd(32'h0010_0009, OP_CONF);
        chk("room", 1, cfg.room_line_echo_en);
        chk("vockeep", 8'h40, cfg.voc);
        cmd(32'h2ac0_000c, OP_CONF);
        chk("hs", 8'hd5, cfg.hs);
        $display("test cfg done");
    endtask
    task automatic t_cx();
        host.xfer(1'b1, OFF_RAM, 32'h0005_ab12, q, e);
        host.xfer(1'b1, OFF_RAM, 32'h0006_cd34, q, e);
        host.xfer(1'b1, OFF_RAM, 32'h000f_7700, q, e);
        host.xfer(1'b1, OFF_RAM, 32'h0000_2200, q, e);
        cmd(32'h0000_0005, OP_CX_READ);
        rdc("cx", OFF_CX, 32'h0000_abcd);
        cmd(32'h0000_000f, OP_CX_READ);
        rdc("cxwrap", OFF_CX, 32'h0000_7722);
        $display("test cx done");
    endtask
    task automatic t_err_tone();
        @(posedge pclk);
        err_set <= 8'hff;
        @(posedge pclk);
        err_set <= '0;
        cmd(32'h0000_000f, OP_ERR_CLEAR);
        rdc("system_error_byte", OFF_ERR, 32'h0000_00f0);
        cmd(32'h3ffe_1002, OP_TONE_DEF);
        chk("tone", {12'he10, 8'h3f}, tones[2]);
        cmd(32'h008c_3403, OP_MONITOR);
        chk("slot", {12'hc34, 1'b1}, slots[3]);
        $display("test err tone done");
    endtask
    task automatic t_irq();
        int b;
        cmd(32'h0000_0001, OP_IRQ_MASK);
        rdc("mask", OFF_MASK, 32'h0000_0001);
        b = n_irq;
        status0 <= 8'h02;
        repeat (3) @(posedge pclk);
        chk("irqmasked", b, n_irq);
        status0 <= 8'h03;
        repeat (3) @(posedge pclk);
        chk("irq", b + 1, n_irq);
        $display("test irq done");
    endtask
    task automatic t_line_framing_cmd();
        for (int i = 0; i < 4; i++) begin
            cmd(i, OP_LINE_FRAMING_CMD);
            chk("txfmt", i, line_cfg.tx_format);
            chk("rxfmt", (i == 1 || i == 3) ? 0 : i, line_cfg.rx_format);
        end
        cmd(32'h0000_2504, OP_LINE_FRAMING_CMD);
        chk("uart", {3'h4, 3'h4, 2'b01, 2'b01, 1'b1}, line_cfg);
        cmd(32'h0000_0005, OP_LINE_FRAMING_CMD);
        chk("fmtkeep", 4, line_cfg.tx_format);
        $display("test line_framing_cmd done");
    endtask
    task automatic t_misc();
        int h, f, a;
        h = n_hs;
        f = n_fw;
        cmd(0, OP_HANDSHAKE);
        chk("hsstart", h + 1, n_hs);
        host.xfer(1'b0, OFF_ACK, '0, q, e);
        chk("hsact", 1, q[8]);
        hs_done <= 1'b1;
        cmd(0, OP_RELEASE);
        hs_done <= 1'b0;
        rdc("rel", OFF_REL, {16'h0, HW_REL, SW_REL});
        cmd(32'h7856_3412, OP_FW_CALL);
        chk("call", 32'h3412_7856, call);
        chk("fwcall", f + 1, n_fw);
        host.xfer(1'b0, OFF_ACK, '0, q, e);
        chk("hsidle", 0, q[8]);
        chk("ackcnt", n_cmd[7:0], q[7:0]);
        chk("acks", n_cmd, n_ack);
        a = n_ack;
        cmd(0, OP_INIT);
        chk("initack", a, n_ack);
        chk("restart", 1, n_rst);
        chk("initcfg", CFG_RST, cfg);
        rdc("initmask", OFF_MASK, {16'h0, MASK1_RST, MASK0_RST});
        $display("test misc done");
    endtask
    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_cfg();
        t_cx();
        t_err_tone();
        t_irq();
        t_line_framing_cmd();
        t_misc();
        final_report();
    end
endmodule
